// File: rtl/pafs_pkg.sv
// Package with sub-register indices, reset values and pin constants.
package pafs_pkg;
    // Data width of the address, control and sub-registers
    localparam int            DW              = 8;
    // Sub-register indices written into the port address register
    localparam logic [7:0]    SUB_DIR         = 8'h01;
    localparam logic [7:0]    SUB_AFEN        = 8'h02;
    localparam logic [7:0]    SUB_FSET1       = 8'h07;
    localparam logic [7:0]    SUB_FSET2       = 8'h08;
    // Reset values of the alternate-function enable sub-register
    localparam logic [7:0]    AFEN_RST_ABC    = 8'h00;
    localparam logic [7:0]    AFEN_RST_D      = 8'h01;
    localparam logic [7:0]    AFEN_RST_A8PIN  = 8'h04;
    // Other reset values; direction resets to all inputs
    localparam logic [7:0]    DIR_RST         = 8'hff;
    localparam logic [7:0]    FSET_RST        = 8'h00;
    localparam logic [7:0]    ADDR_RST        = 8'h00;
    // Answer on an unmapped sub-register index
    localparam logic [7:0]    UNMAPPED_RD     = 8'h00;
    // Port B pin positions with special meaning
    localparam int            PB_EXTERNAL_CLOCK_INPUT_PIN    = 3;
    localparam int            PB_VREF_PIN     = 5;
    // Port B analog functions exist on pins 0..5 only
    localparam logic [7:0]    PB_ANALOG_MASK  = 8'h3f;
    // Port identity
    typedef enum logic [1:0] {
        PAFS_PORT_A = 2'h0,
        PAFS_PORT_B = 2'h1,
        PAFS_PORT_C = 2'h2,
        PAFS_PORT_D = 2'h3
    } pafs_port_t;
endpackage

// File: rtl/pafs_port_mux.sv
// Pin multiplexer: GPIO versus alternate function per port pin.
`timescale 1ns/10ps
module pafs_port_mux #(
    parameter pafs_pkg::pafs_port_t PORT       = pafs_pkg::PAFS_PORT_B,
    parameter bit                   EIGHT_PIN  = 1'b0,
    parameter bit                   PINS28     = 1'b1,
    parameter int                   NPIN       = 8
) (
    // Clock, reset, enable
    input  wire logic             i_clk_sys,
    input  wire logic             i_nrst,
    input  wire logic             i_ce,
    // Port address and control register access
    input  wire logic             i_addr_wr,
    input  wire logic             i_ctl_wr,
    input  wire logic [pafs_pkg::DW-1:0] i_wdata,
    output logic      [pafs_pkg::DW-1:0] o_addr,
    output logic      [pafs_pkg::DW-1:0] o_rdata,
    // GPIO data path
    input  wire logic [NPIN-1:0]  i_gpio_out,
    output logic      [NPIN-1:0]  o_gpio_in,
    // Peripheral alternate path
    input  wire logic [NPIN-1:0]  i_alt_out,
    input  wire logic [NPIN-1:0]  i_alt_oe,
    output logic      [NPIN-1:0]  o_alt_active,
    output logic      [NPIN-1:0]  o_analog_sel,
    output logic                  o_ext_clk_en,
    output logic                  o_ext_clk,
    // Pad
    input  wire logic [NPIN-1:0]  i_pin_i,
    output logic      [NPIN-1:0]  o_pin_o,
    output logic      [NPIN-1:0]  o_pin_oe
);
    import pafs_pkg::*;

    // Elaboration check: the pin count must equal the one-byte register width
    if (NPIN != DW) begin : g_bad_npin
        $error("NPIN must equal the register width");
    end

    // Reset value of the enable register for this port build
    localparam logic [7:0] AFEN_RST =
        (PORT == PAFS_PORT_D) ? AFEN_RST_D :
        ((PORT == PAFS_PORT_A) && EIGHT_PIN) ? AFEN_RST_A8PIN :
        AFEN_RST_ABC;
    localparam bit IS_B = (PORT == PAFS_PORT_B);

    logic [1:0]      rst_sync_r;   // Reset release stages
    logic            rst_n;        // Synchronised reset
    logic [7:0]      addr_r;       // Port address register
    logic [7:0]      dir_r;        // Direction, 1 = input
    logic [7:0]      afen_r;       // Alternate-function enables
    logic [7:0]      fset1_r;      // Function set one
    logic [7:0]      fset2_r;      // Function set two, held only
    logic [7:0]      rdata_r;      // Read data register
    logic [NPIN-1:0] s1_r;         // Pin sync stage one
    logic [NPIN-1:0] s2_r;         // Pin sync stage two
    logic [NPIN-1:0] s3_r;         // Pin sync stage three
    logic [NPIN-1:0] pin_in_r;     // Filtered pin level

    // Reset released through two flops, asserted at once
    always_ff @(posedge i_clk_sys or negedge i_nrst) begin
        if (!i_nrst) begin
            rst_sync_r <= 2'h0;
        end else begin
            rst_sync_r <= {rst_sync_r[0], 1'b1};
        end
    end
    assign rst_n = rst_sync_r[1];

    // Sub-register decode from the held address
    wire wr_dir   = i_ce & i_ctl_wr & (addr_r == SUB_DIR);
    wire wr_afen  = i_ce & i_ctl_wr & (addr_r == SUB_AFEN);
    wire wr_fset1 = i_ce & i_ctl_wr & (addr_r == SUB_FSET1);
    wire wr_fset2 = i_ce & i_ctl_wr & (addr_r == SUB_FSET2);

    // Read selection; unknown indices answer zero
    wire [7:0] rd_mux =
        (addr_r == SUB_DIR)   ? dir_r   :
        (addr_r == SUB_AFEN)  ? afen_r  :
        (addr_r == SUB_FSET1) ? fset1_r :
        (addr_r == SUB_FSET2) ? fset2_r : UNMAPPED_RD;

    // Address register, loaded by software before a control access
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            addr_r <= ADDR_RST;
        end else if (i_ce && i_addr_wr) begin
            addr_r <= i_wdata;
        end
    end

    // Enable sub-register with its build-dependent reset value
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            afen_r <= AFEN_RST;
        end else if (wr_afen) begin
            afen_r <= i_wdata;
        end
    end

    // Direction and function-set sub-registers
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            dir_r   <= DIR_RST;
            fset1_r <= FSET_RST;
            fset2_r <= FSET_RST;
        end else begin
            if (wr_dir) begin
                dir_r <= i_wdata;
            end
            if (wr_fset1) begin
                fset1_r <= i_wdata;
            end
            // Stored so software reads back what it wrote
            if (wr_fset2) begin
                fset2_r <= i_wdata;
            end
        end
    end

    // Read data follows the selected sub-register one cycle late
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            rdata_r <= UNMAPPED_RD;
        end else if (i_ce) begin
            rdata_r <= rd_mux;
        end
    end
    assign o_rdata = rdata_r;
    assign o_addr  = addr_r;

    // Pin input sync; a level counts once stages two and three agree
    always_ff @(posedge i_clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            s1_r     <= '0;
            s2_r     <= '0;
            s3_r     <= '0;
            pin_in_r <= '0;
        end else if (i_ce) begin
            s1_r     <= i_pin_i;
            s2_r     <= s1_r;
            s3_r     <= s2_r;
            pin_in_r <= (s2_r & s3_r) | (pin_in_r & (s2_r | s3_r));
        end
    end
    assign o_gpio_in = pin_in_r;

    // Port B function decode; only set one is consulted
    // Set bit 0 keeps the default, which is real only on pin 3
    logic [7:0] valid_fn;   // Enabled function really exists
    logic [7:0] analog_fn;  // Analog function picked
    generate
        for (genvar n = 0; n < NPIN; n++) begin : g_pin
            localparam bit ANA_OK = PB_ANALOG_MASK[n] &&
                                    ((n != PB_VREF_PIN) || PINS28);
            // Set bit 1 gives analog where it exists
            assign analog_fn[n] = IS_B & fset1_r[n] & ANA_OK;
            assign valid_fn[n]  = !IS_B ? 1'b1 :
                fset1_r[n] ? ANA_OK : (n == PB_EXTERNAL_CLOCK_INPUT_PIN);
            // Peripheral owns only an enabled real function
            assign o_alt_active[n] = afen_r[n] & valid_fn[n];
            assign o_analog_sel[n] = afen_r[n] & analog_fn[n];
            // Output path: GPIO under direction, else peripheral
            assign o_pin_oe[n] = afen_r[n] ?
                (o_alt_active[n] & ~analog_fn[n] & i_alt_oe[n]) :
                ~dir_r[n];
            assign o_pin_o[n] = afen_r[n] ?
                (o_alt_active[n] & i_alt_out[n]) :
                i_gpio_out[n];
        end
    endgenerate

    // External clock input on Port B pin 3 default function
    assign o_ext_clk_en = IS_B & afen_r[PB_EXTERNAL_CLOCK_INPUT_PIN] &
                          ~fset1_r[PB_EXTERNAL_CLOCK_INPUT_PIN];
    assign o_ext_clk    = o_ext_clk_en & pin_in_r[PB_EXTERNAL_CLOCK_INPUT_PIN];

    // Checks
    default clocking cb @(posedge i_clk_sys);
    endclocking
    default disable iff (!rst_n);

    property p_reset_val;
        $rose(rst_n) |-> (afen_r == AFEN_RST);
    endproperty
    a_reset_val: assert property (p_reset_val)
        else $error("enable register reset value wrong");

    // Write lands at once; back-to-back accesses stay legal
    property p_afen_write;
        wr_afen |=> (afen_r == $past(i_wdata));
    endproperty
    a_afen_write: assert property (p_afen_write)
        else $error("enable register write lost");

    // Enable read-back one enabled edge after the index is held
    property p_afen_read;
        (i_ce && (addr_r == SUB_AFEN)) |=> (o_rdata == $past(afen_r));
    endproperty
    a_afen_read: assert property (p_afen_read)
        else $error("enable register read-back wrong");

    property p_no_select_alone;
        (o_alt_active & ~afen_r) == '0 && (o_analog_sel & ~afen_r) == '0;
    endproperty
    a_no_select_alone: assert property (p_no_select_alone)
        else $error("function active without enable");

    property p_gpio_dir;
        (~afen_r & (o_pin_oe ^ ~dir_r)) == '0 &&
        (~afen_r & (o_pin_o ^ i_gpio_out)) == '0;
    endproperty
    a_gpio_dir: assert property (p_gpio_dir)
        else $error("GPIO path not under direction bit");

    property p_alt_override;
        ((afen_r & valid_fn) & (o_pin_o ^ i_alt_out)) == '0;
    endproperty
    a_alt_override: assert property (p_alt_override)
        else $error("alternate data not on pin");

    property p_external_clock_input_sel;
        (IS_B && afen_r[3] && !fset1_r[3]) |->
            (o_ext_clk_en && !o_analog_sel[3]);
    endproperty
    a_external_clock_input_sel: assert property (p_external_clock_input_sel)
        else $error("pin 3 default function not clock input");

    property p_no_fn_67;
        o_analog_sel[7:6] == 2'h0 && (!IS_B || o_alt_active[7:6] == 2'h0);
    endproperty
    a_no_fn_67: assert property (p_no_fn_67)
        else $error("function on pin 6 or 7");

    property p_set2_ignored;
        wr_fset2 |=> $stable(o_analog_sel) && $stable(o_alt_active);
    endproperty
    a_set2_ignored: assert property (p_set2_ignored)
        else $error("set two changed function choice");

    property p_vref_build;
        !PINS28 |-> !o_analog_sel[5];
    endproperty
    a_vref_build: assert property (p_vref_build)
        else $error("reference selected outside 28-pin build");

    property p_reserved_undriven;
        ((afen_r & ~valid_fn) & (o_pin_oe | o_pin_o)) == '0;
    endproperty
    a_reserved_undriven: assert property (p_reserved_undriven)
        else $error("reserved function drives pin");

    property p_cov_analog;
        wr_afen ##1 (o_analog_sel != '0);
    endproperty
    c_cov_analog: cover property (p_cov_analog);

    property p_cov_external_clock_input;
        o_ext_clk_en ##1 o_ext_clk;
    endproperty
    c_cov_external_clock_input: cover property (p_cov_external_clock_input);

    property p_cov_gpio_out;
        (afen_r == '0) && (o_pin_oe != '0);
    endproperty
    c_cov_gpio_out: cover property (p_cov_gpio_out);
endmodule

// File: testbench/pafs_pad_model.sv
// Pad-side partner: resolves each pin from the design drive and the board.
`timescale 1ns/10ps
module pafs_pad_model (
    // Design drive
    input  wire logic [7:0] i_pin_o,
    input  wire logic [7:0] i_pin_oe,
    // Board drive, used only where the design lets the pin go
    input  wire logic [7:0] i_board,
    output logic      [7:0] o_level
);
    // Driven pins show the design value; released ones never keep it
    assign o_level = (i_pin_oe & i_pin_o) |
                     (~i_pin_oe & i_board);
endmodule

// File: testbench/test_port_alternate_function_select.sv
// Self-checking bench for the Port B alternate-function pin multiplexer.
`timescale 1ns/10ps
module test_port_alternate_function_select;
    import pafs_pkg::*;
    // Stimulus, all given a value at time zero
    logic       i_clk_sys = 1'b0;
    logic       i_nrst    = 1'b1;
    logic       i_ce      = 1'b1;
    logic       i_addr_wr = 1'b0;
    logic       i_ctl_wr  = 1'b0;
    logic [7:0] i_wdata   = 8'h00;
    logic [7:0] i_gpio    = 8'h00;
    logic [7:0] i_alt_out = 8'h00;
    logic [7:0] i_alt_oe  = 8'h00;
    logic [7:0] board     = 8'h00;
    // Design outputs and resolved pad level
    logic [7:0] o_addr, o_rdata, o_gpio_in, o_act, o_ana, o_pin_o, o_pin_oe;
    logic [7:0] level;
    logic       o_ext_clk_en, o_ext_clk;
    // Reference registers, counters
    int         m_dir, m_en, m_s1, m_s2, m_lvl, seed, cycles;
    int         n_mismatch, comparisons;

    always #20 i_clk_sys = ~i_clk_sys;

    pafs_port_mux #(.PORT(PAFS_PORT_B), .EIGHT_PIN(1'b0), .PINS28(1'b1),
        .NPIN(8)) dut (.i_clk_sys(i_clk_sys), .i_nrst(i_nrst), .i_ce(i_ce),
        .i_addr_wr(i_addr_wr), .i_ctl_wr(i_ctl_wr), .i_wdata(i_wdata),
        .o_addr(o_addr), .o_rdata(o_rdata), .i_gpio_out(i_gpio),
        .o_gpio_in(o_gpio_in), .i_alt_out(i_alt_out), .i_alt_oe(i_alt_oe),
        .o_alt_active(o_act), .o_analog_sel(o_ana),
        .o_ext_clk_en(o_ext_clk_en), .o_ext_clk(o_ext_clk),
        .i_pin_i(level), .o_pin_o(o_pin_o), .o_pin_oe(o_pin_oe));

    pafs_pad_model pad (.i_pin_o(o_pin_o), .i_pin_oe(o_pin_oe),
        .i_board(board), .o_level(level));

    // Verdict and end of run, reached from the sequence or the timeout
    task automatic conclude;
        $display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Value comparison; case inequality so an unknown matches only an identical unknown
    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("unexpected at %0t got %h exp %h", $time, got, exp);
        end
    endtask

    // Sub-register write: index first, then data, one enabled edge each
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge i_clk_sys);
        i_addr_wr = 1'b1;
        i_wdata   = a;
        @(negedge i_clk_sys);
        i_addr_wr = 1'b0;
        i_ctl_wr  = 1'b1;
        i_wdata   = d;
        @(negedge i_clk_sys);
        i_ctl_wr  = 1'b0;
    endtask

    // Register read; read data lags the index by one enabled edge
    task automatic cmp_reg(input logic [7:0] a, input logic [7:0] e);
        @(negedge i_clk_sys);
        i_addr_wr = 1'b1;
        i_wdata   = a;
        @(negedge i_clk_sys);
        i_addr_wr = 1'b0;
        @(negedge i_clk_sys);
        compare(o_rdata, e);
        compare(o_addr, a);
    endtask

    // Pin outputs from the reference registers; set two plays no part
    task automatic check_pins;
        logic [7:0] en, s1, v, an, oe, po;
        en = 8'(m_en);
        s1 = 8'(m_s1);
        v  = (s1 & PB_ANALOG_MASK) | (~s1 & 8'h08);
        an = en & s1 & PB_ANALOG_MASK;
        oe = (~en & ~8'(m_dir)) | (en & v & ~an & i_alt_oe);
        po = (~en & i_gpio) | (en & v & i_alt_out);
        // Level the pad should settle to, for the input path check
        m_lvl = (oe & po) | (~oe & board);
        compare(o_act, en & v);
        compare(o_ana, an);
        compare(o_pin_oe, oe);
        compare(o_pin_o, po);
        compare({7'h00, o_ext_clk_en}, {7'h00, en[3] & ~s1[3]});
    endtask

    // Hang guard, far above the roughly 1100 cycles the run needs
    always @(posedge i_clk_sys) begin
        cycles++;
        if (cycles == 20000) begin
            n_mismatch++;
            conclude();
        end
    end

    initial begin
        // Falling edge after time zero so the async reset really fires
        #1 i_nrst = 1'b0;
        seed  = 32'h24f1;
        m_dir = 8'hff;
        repeat (4) @(negedge i_clk_sys);
        i_nrst = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        cmp_reg(SUB_AFEN, AFEN_RST_ABC);
        cmp_reg(SUB_DIR, DIR_RST);
        check_pins();
        // First 16 passes walk one pin at a time under both set-one codes
        for (int i = 0; i < 64; i++) begin
            m_dir = $random(seed) & 8'hff;
            m_s1  = (i < 16) ? ((i < 8) ? 0 : 8'hff) : ($random(seed) & 8'hff);
            m_en  = (i < 16) ? (1 << (i % 8)) : ($random(seed) & 8'hff);
            // Random passes enable only pins with a real function
            if (i >= 16) begin
                m_en = m_en & ((m_s1 & PB_ANALOG_MASK) | (~m_s1 & 8'h08));
            end
            m_s2  = $random(seed) & 8'hff;
            wr(SUB_DIR, 8'(m_dir));
            wr(SUB_FSET1, 8'(m_s1));
            wr(SUB_FSET2, 8'(m_s2));
            wr(SUB_AFEN, 8'(m_en));
            i_gpio    = 8'($random(seed));
            i_alt_out = 8'($random(seed));
            i_alt_oe  = 8'($random(seed));
            board     = 8'($random(seed));
            @(negedge i_clk_sys);
            check_pins();
            // Pad level needs four enabled edges through the input sync
            repeat (3) @(negedge i_clk_sys);
            compare(o_gpio_in, 8'(m_lvl));
            compare({7'h00, o_ext_clk},
                    {7'h00, m_en[3] & ~m_s1[3] & m_lvl[3]});
        end
        cmp_reg(SUB_FSET2, 8'(m_s2));
        cmp_reg(8'h0a, UNMAPPED_RD);
        // Writes with the clock enable low must leave everything alone
        i_ce = 1'b0;
        wr(SUB_AFEN, ~8'(m_en));
        i_ce = 1'b1;
        cmp_reg(SUB_AFEN, 8'(m_en));
        // Reset in mid-run returns the enable to its reset value
        @(negedge i_clk_sys);
        i_nrst = 1'b0;
        repeat (4) @(negedge i_clk_sys);
        i_nrst = 1'b1;
        repeat (4) @(negedge i_clk_sys);
        m_en  = 0;
        m_s1  = 0;
        m_dir = 8'hff;
        check_pins();
        cmp_reg(SUB_AFEN, AFEN_RST_ABC);
        conclude();
    end
endmodule
